// ### pukol_key_edge.sv
// press detector: one pulse per key press
`timescale 1ns/100ps
`default_nettype none
module pukol_key_edge #(
    parameter int N = pukol_pkg::KEY_COUNT
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic [N-1:0] key_in,
    pukol_key_if.src keys
);
    logic [N-1:0] prev; // key levels one cycle ago
    logic [N-1:0] pulse; // registered press pulses
    logic [N-1:0] next_prev;
    logic [N-1:0] next_pulse;

    // per-key rising edge, so a held key acts once
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_key
            always_comb begin
                next_prev[g] = key_in[g];
                next_pulse[g] = key_in[g] & ~prev[g];
            end
        end
    endgenerate

    // register history and pulses
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            prev <= N'(pukol_pkg::RST_KEYS);
            pulse <= N'(pukol_pkg::RST_KEYS);
        end else begin
            prev <= next_prev;
            pulse <= next_pulse;
        end
    end

    assign keys.level = prev;
    assign keys.rise = pulse;
endmodule : pukol_key_edge
`default_nettype wire

// ### pukol_key_if.sv
// carrier for key levels and their press pulses
`timescale 1ns/100ps
`default_nettype none
interface pukol_key_if;
    logic [pukol_pkg::KEY_COUNT-1:0] level; // key levels as sampled one cycle ago
    logic [pukol_pkg::KEY_COUNT-1:0] rise; // one-cycle press pulses
    // edge detector drives both
    modport src (output level, output rise);
    // decode logic reads both
    modport dst (input level, input rise);
endinterface : pukol_key_if
`default_nettype wire

// ### pukol_panel_model.sv
// operator panel model: user keys pressed and released by a stimulus task
`timescale 1ns/100ps
`default_nettype none
module pukol_panel_model (
    input wire logic sys_clk_in,
    output logic [2:0] keys_out
);
    // all keys released at start
    initial keys_out = 3'h0;
    // hold a set of keys, then release them for one sampled cycle
    task automatic press(input logic [2:0] mask, input int hold);
        @(negedge sys_clk_in);
        keys_out = mask;
        repeat (hold) @(negedge sys_clk_in);
        keys_out = 3'h0;
        @(negedge sys_clk_in);
    endtask : press
endmodule : pukol_panel_model
`default_nettype wire

// ### pukol_pkg.sv
// constants and types for the panel user-key and lamp logic
package pukol_pkg;
    // key positions within the key vector
    localparam int KEY_COUNT = 3;
    localparam int KEY_FIRST = 0;
    localparam int KEY_SECOND = 1;
    localparam int KEY_THIRD = 2;
    // product variant codes on variant_in
    localparam logic [1:0] VARIANT_INTEGRAL = 2'h0;
    localparam logic [1:0] VARIANT_HORIZONTAL = 2'h1;
    localparam logic [1:0] VARIANT_VERTICAL = 2'h2;
    // reset values of every output register
    localparam logic RST_LAMP = 1'b0;
    localparam logic RST_VALVE = 1'b0;
    localparam logic RST_BLOW = 1'b0;
    localparam logic RST_JOG = 1'b0;
    localparam logic RST_REF = 1'b0;
    localparam logic [2:0] RST_KEYS = 3'h0;
    // what a user key does once decoded
    typedef enum logic [1:0] {
        ROLE_NONE,
        ROLE_JOG,
        ROLE_VALVE,
        ROLE_REF
    } pukol_role_e;
endpackage : pukol_pkg

// ### pukol_top.sv
// panel user-key function select and status lamp outputs
// How it works
// - integral, mode clear, fifth on: key one jogs plus
// - integral, mode clear, fifth off: key one toggles valve
// - mode one set: key one returns reference one
// - vertical, mode clear: key one only toggles valve
// - integral key two: jog minus, else valve toggle
// - mode two set: key two returns reference two
// - vertical, mode clear: key two toggles valve
// - key three drives spindle blowing
// - red lamp on during alarm
// - yellow lamp when no alarm, no program
// - green lamp while program runs
`timescale 1ns/100ps
`default_nettype none
module pukol_top (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic first_user_key_in,
    input wire logic second_user_key_in,
    input wire logic third_user_key_in,
    input wire logic first_key_mode_bit_in,
    input wire logic second_key_mode_bit_in,
    input wire logic [1:0] variant_in,
    input wire logic fifth_axis_enable_in,
    input wire logic alarm_in,
    input wire logic program_running_in,
    output logic red_lamp_output_out,
    output logic yellow_lamp_output_out,
    output logic green_lamp_output_out,
    output logic spindle_blowing_output_out,
    output logic watering_valve_output_out,
    output logic fifth_jog_pos_out,
    output logic fifth_jog_neg_out,
    output logic ref_return_first_out,
    output logic ref_return_second_out
);
    // decode a user key's role from mode bit, variant and fifth axis
    function automatic pukol_pkg::pukol_role_e key_role(
        input logic mode,
        input logic [1:0] variant,
        input logic fifth
    );
        pukol_pkg::pukol_role_e role;
        role = pukol_pkg::ROLE_NONE;
        if (mode) begin
            role = pukol_pkg::ROLE_REF; // any variant
        end else if (variant == pukol_pkg::VARIANT_VERTICAL) begin
            role = pukol_pkg::ROLE_VALVE; // vertical never jogs
        end else if (fifth) begin
            role = pukol_pkg::ROLE_JOG;
        end else begin
            role = pukol_pkg::ROLE_VALVE;
        end
        return role;
    endfunction : key_role

    pukol_key_if keys (); // levels and press pulses
    pukol_pkg::pukol_role_e role_first; // first key role now
    pukol_pkg::pukol_role_e role_second; // second key role now

    // output registers and their next values
    logic red, yellow, green;
    logic blow, valve, jog_pos, jog_neg, ref_first, ref_second;
    logic next_red, next_yellow, next_green;
    logic next_blow, next_valve, next_jog_pos, next_jog_neg;
    logic next_ref_first, next_ref_second;
    logic valve_hit; // a key asked for a valve toggle
    // idle values of the pulse and level outputs, declared before first use
    localparam logic RST_JOG_C = pukol_pkg::RST_JOG;
    localparam logic RST_REF_C = pukol_pkg::RST_REF;

    // press detection for all three keys
    pukol_key_edge #(
        .N(pukol_pkg::KEY_COUNT)
    ) u_edge (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .key_in({third_user_key_in, second_user_key_in, first_user_key_in}),
        .keys(keys.src)
    );

    // roles follow the configuration every cycle
    assign role_first = key_role(first_key_mode_bit_in, variant_in, fifth_axis_enable_in);
    assign role_second = key_role(second_key_mode_bit_in, variant_in, fifth_axis_enable_in);

    // key actions: jogs follow held keys, the rest act on presses
    always_comb begin
        next_jog_pos = RST_JOG_C;
        next_jog_neg = RST_JOG_C;
        next_ref_first = RST_REF_C;
        next_ref_second = RST_REF_C;
        valve_hit = 1'b0;
        case (role_first)
            pukol_pkg::ROLE_JOG: next_jog_pos = keys.level[pukol_pkg::KEY_FIRST];
            pukol_pkg::ROLE_VALVE: valve_hit = keys.rise[pukol_pkg::KEY_FIRST];
            pukol_pkg::ROLE_REF: next_ref_first = keys.rise[pukol_pkg::KEY_FIRST];
            default: next_jog_pos = RST_JOG_C;
        endcase
        case (role_second)
            pukol_pkg::ROLE_JOG: next_jog_neg = keys.level[pukol_pkg::KEY_SECOND];
            pukol_pkg::ROLE_VALVE: begin
                valve_hit = valve_hit | keys.rise[pukol_pkg::KEY_SECOND];
            end
            pukol_pkg::ROLE_REF: next_ref_second = keys.rise[pukol_pkg::KEY_SECOND];
            default: next_jog_neg = RST_JOG_C;
        endcase
        // one toggle per cycle even if both keys press together
        next_valve = valve ^ valve_hit;
        next_blow = blow ^ keys.rise[pukol_pkg::KEY_THIRD];
    end

    // status lamps from alarm and run state
    always_comb begin
        next_red = alarm_in;
        next_yellow = ~alarm_in & ~program_running_in;
        next_green = program_running_in;
    end

    // register every output
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            red <= pukol_pkg::RST_LAMP;
            yellow <= pukol_pkg::RST_LAMP;
            green <= pukol_pkg::RST_LAMP;
            blow <= pukol_pkg::RST_BLOW;
            valve <= pukol_pkg::RST_VALVE;
            jog_pos <= pukol_pkg::RST_JOG;
            jog_neg <= pukol_pkg::RST_JOG;
            ref_first <= pukol_pkg::RST_REF;
            ref_second <= pukol_pkg::RST_REF;
        end else begin
            red <= next_red;
            yellow <= next_yellow;
            green <= next_green;
            blow <= next_blow;
            valve <= next_valve;
            jog_pos <= next_jog_pos;
            jog_neg <= next_jog_neg;
            ref_first <= next_ref_first;
            ref_second <= next_ref_second;
        end
    end

    // drive ports; spare outputs are not brought out
    assign red_lamp_output_out = red;
    assign yellow_lamp_output_out = yellow;
    assign green_lamp_output_out = green;
    assign spindle_blowing_output_out = blow;
    assign watering_valve_output_out = valve;
    assign fifth_jog_pos_out = jog_pos;
    assign fifth_jog_neg_out = jog_neg;
    assign ref_return_first_out = ref_first;
    assign ref_return_second_out = ref_second;

    // checks on the outputs against their causes
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    // integral-style jog follows held first key
    jog_pos_a: assert property (
        (variant_in != pukol_pkg::VARIANT_VERTICAL && !first_key_mode_bit_in
         && fifth_axis_enable_in) |=> (jog_pos == $past(keys.level[0])))
        else $error("first key jog does not follow key");
    // lone first-key press toggles valve
    valve_first_a: assert property (
        (role_first == pukol_pkg::ROLE_VALVE && keys.rise[0]
         && role_second != pukol_pkg::ROLE_VALVE) |=> (valve != $past(valve)))
        else $error("first key press did not toggle valve");
    // mode one gives a reference-return pulse
    ref_first_a: assert property (
        (first_key_mode_bit_in && keys.rise[0]) |=> ref_first)
        else $error("reference one return not commanded");
    // vertical variant never jogs
    vert_nojog_a: assert property (
        $past(variant_in == pukol_pkg::VARIANT_VERTICAL) && !$past(srst_in)
        |-> (!jog_pos && !jog_neg))
        else $error("vertical variant produced a jog");
    // second key jogs minus when enabled
    jog_neg_a: assert property (
        (variant_in == pukol_pkg::VARIANT_INTEGRAL && !second_key_mode_bit_in
         && fifth_axis_enable_in && keys.level[1]) |=> jog_neg)
        else $error("second key minus jog missing");
    // mode two gives the second return pulse
    ref_second_a: assert property (
        (second_key_mode_bit_in && keys.rise[1]) |=> ref_second ##1 !ref_second)
        else $error("reference two return not a single pulse");
    // vertical second key toggles valve
    valve_second_a: assert property (
        (variant_in == pukol_pkg::VARIANT_VERTICAL && !second_key_mode_bit_in
         && !fifth_axis_enable_in && keys.rise[1]) |=> (valve != $past(valve)))
        else $error("second key press did not toggle valve");
    // third key press flips blowing
    blow_a: assert property (
        keys.rise[2] |=> (blow != $past(blow)))
        else $error("spindle blowing not switched");
    // lamps track alarm and run state
    red_lamp_a: assert property (
        alarm_in |=> red && !yellow)
        else $error("red lamp missing in alarm");
    yellow_lamp_a: assert property (
        (!alarm_in && !program_running_in) |=> yellow && !green)
        else $error("yellow lamp missing while idle");
    green_lamp_a: assert property (
        program_running_in |=> green && !yellow)
        else $error("green lamp missing while running");
    // held key returns only once
    one_shot_a: assert property (
        ref_first |=> !ref_first)
        else $error("reference return repeated on held key");

    // main scenarios
    cover_jog_c: cover property (jog_pos ##1 !jog_pos);
    cover_valve_c: cover property ($rose(valve) ##[1:50] $fell(valve));
    cover_ref_c: cover property (ref_first ##[1:20] ref_second);
    cover_blow_c: cover property ($rose(blow));
endmodule : pukol_top
`default_nettype wire

// ### tb_pukol_top.sv
// self-checking bench for the user-key and lamp logic
`timescale 1ns/100ps
`default_nettype none
module tb_pukol_top;
    logic sys_clk_in = 1'b0; // 40 MHz
    logic srst_in = 1'b1; // reset held at start
    logic m1 = 1'b0, m2 = 1'b0, fifth = 1'b0, alarm = 1'b0, run = 1'b0;
    logic [1:0] variant = 2'h0;
    logic [2:0] keys; // from the panel model
    logic red, yel, grn, blow, valve, jp, jn, r1, r2;
    logic [7:0] notes[$]; // expected output events, oldest first
    logic exp_valve = 1'b0, exp_blow = 1'b0; // expected toggle states
    logic pv = 1'b0, pb = 1'b0, pjp = 1'b0, pjn = 1'b0; // previous outputs
    int fails = 0, compares = 0, seed = 79;
    // directed {m1, m2, fifth, variant}: integral jog, vertical valve,
    // vertical with fifth on, integral valve with ref two, horizontal refs
    logic [4:0] cfgs[5] = '{5'h04, 5'h02, 5'h06, 5'h08, 5'h19};
    // clock
    always #12.5 sys_clk_in = ~sys_clk_in;
    pukol_panel_model panel (.sys_clk_in(sys_clk_in), .keys_out(keys));
    // only named outputs exist; spare outputs stay for logic edits
    pukol_top uut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
        .first_user_key_in(keys[0]), .second_user_key_in(keys[1]),
        .third_user_key_in(keys[2]), .first_key_mode_bit_in(m1),
        .second_key_mode_bit_in(m2), .variant_in(variant),
        .fifth_axis_enable_in(fifth), .alarm_in(alarm), .program_running_in(run),
        .red_lamp_output_out(red), .yellow_lamp_output_out(yel),
        .green_lamp_output_out(grn), .spindle_blowing_output_out(blow),
        .watering_valve_output_out(valve), .fifth_jog_pos_out(jp),
        .fifth_jog_neg_out(jn), .ref_return_first_out(r1), .ref_return_second_out(r2));
    // compare one value, report and count
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check
    // match an observed event with the oldest note
    task automatic take(input logic [7:0] seen);
        if (notes.size() == 0) check(seen, 8'hff);
        else check(seen, notes.pop_front());
    endtask : take
    // watcher: turns output changes into events at settled times
    always @(negedge sys_clk_in) begin
        if (!srst_in) begin
            if (r1) take(8'h10);
            if (r2) take(8'h20);
            if (valve !== pv) take({4'h3, 3'h0, valve});
            if (blow !== pb) take({4'h4, 3'h0, blow});
            if (jp && !pjp) take(8'h50);
            if (jn && !pjn) take(8'h60);
            pv = valve;
            pb = blow;
            pjp = jp;
            pjn = jn;
        end
    end
    // note the expected effect of key k, then press it
    task automatic act(input int k);
        logic [2:0] mask;
        mask = 3'h1 << k;
        if (k == 2) begin
            exp_blow = ~exp_blow;
            notes.push_back({4'h4, 3'h0, exp_blow});
        end else if (k == 0 ? m1 : m2) notes.push_back(k == 0 ? 8'h10 : 8'h20);
        else if (variant != pukol_pkg::VARIANT_VERTICAL && fifth)
            notes.push_back(k == 0 ? 8'h50 : 8'h60);
        else begin
            exp_valve = ~exp_valve;
            notes.push_back({4'h3, 3'h0, exp_valve});
        end
        panel.press(mask, 1 + ($random(seed) & 2)); // held presses must not repeat
    endtask : act
    // verdict and end of run
    task automatic wrap_up;
        $display("counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // main sequence
    initial begin
        repeat (6) @(negedge sys_clk_in);
        srst_in = 1'b0;
        @(negedge sys_clk_in);
        // random configurations, back-to-back presses of each key
        for (int i = 0; i < 30; i++) begin
            {m1, m2, fifth} = 3'($random(seed));
            variant = 2'($random(seed));
            repeat (2) act(i % 3);
            repeat (4) @(negedge sys_clk_in);
        end
        // directed roles, so every decode branch is met at least once
        for (int i = 0; i < 5; i++) begin
            {m1, m2, fifth, variant} = cfgs[i];
            act(0);
            act(1);
            repeat (4) @(negedge sys_clk_in);
        end
        // both keys on the valve at once toggle it once
        {m1, m2, fifth, variant} = 5'h00;
        exp_valve = ~exp_valve;
        notes.push_back({4'h3, 3'h0, exp_valve});
        panel.press(3'h3, 1);
        repeat (6) @(negedge sys_clk_in);
        check(8'(notes.size()), 8'h00);
        $display("test keys done");
        // lamps follow alarm and program state
        for (int i = 0; i < 4; i++) begin
            alarm = i[0];
            run = i[1];
            repeat (2) @(negedge sys_clk_in);
            check({7'h00, red}, {7'h00, alarm});
            check({7'h00, yel}, {7'h00, !alarm && !run});
            check({7'h00, grn}, {7'h00, run});
        end
        $display("test lamps done");
        wrap_up();
    end
    // watchdog far beyond the expected run length
    initial begin
        #500000;
        fails++;
        wrap_up();
    end
endmodule : tb_pukol_top
`default_nettype wire
